// ### boot_loader_pkg.sv
// constants, types and register map of the serial boot loader front end
// assumes one 25 MHz clock and a plain strobe register port
//
// Notes on behaviour
// - uart baud is cpu clock over 32 times reload plus one
// - reload is measured count minus 36, divided by 72
// - boot mode entered when boot select is low at reset release
// - can zero frame timed over five dominant groups plus four stuff bits
// - after measuring, can port gets timing, tx output and is enabled
// - acknowledge object prepared, sent only on host remote request
// - acknowledge is id e6, length 3, code then ident low, high
// - host repeats zero frame until the configured port acknowledges
// - can tx pin stays undriven for a delay after the zero frame
// - watchdog held disabled throughout boot mode
// - fetches from internal main flash blocked in boot mode
// - config bit 10 forced set, bit 9 follows bus width strap
// - can boot loads peripheral select with 042d
// - can boot clears can status word and drives tx high
// - both rx lines polled, timer runs from first low until high (uart) or the fifth rising edge (can)
// - received bytes stored from load base, then start pulse
package boot_loader_pkg;

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam logic [7:0] REG_RELOAD = 8'h0c;
   localparam logic [7:0] REG_CAN_BRP = 8'h10;
   localparam logic [7:0] REG_CAN_SC = 8'h14;
   localparam logic [7:0] REG_SYSCFG = 8'h18;
   localparam logic [7:0] REG_XPER = 8'h1c;
   localparam logic [7:0] REG_IDENT = 8'h20;
   localparam logic [7:0] REG_LOAD_CNT = 8'h24;
   localparam logic [7:0] REG_RAM_IDX = 8'h28;
   localparam logic [7:0] REG_RAM_DATA = 8'h2c;
   localparam int CTRL_RESTART = 0;

   // ---------------------------------------------------------------
   // measurement and loading
   // ---------------------------------------------------------------
   localparam int TMR_W = 17;
   localparam logic [1:0] UART_PRESCALE_LAST = 2'h3;
   localparam logic [16:0] RELOAD_OFFSET = 17'h00024;
   localparam logic [16:0] RELOAD_DIV = 17'h00048;
   localparam logic [16:0] CAN_BRP_DIV = 17'h005ab;
   localparam logic [2:0] CAN_STUFF_LAST = 3'h4;
   localparam logic [7:0] UART_LOAD_LAST = 8'h1f;
   localparam logic [7:0] CAN_LOAD_LAST = 8'h7f;
   localparam logic [15:0] LOAD_BASE = 16'hfa40;

   // ---------------------------------------------------------------
   // boot configuration values
   // ---------------------------------------------------------------
   localparam logic [15:0] SYSCFG_BOOT = 16'h0400;
   localparam int SYSCFG_BYTE_HIGH_DISABLE_BIT = 9;
   localparam logic [15:0] SYSCFG_XPEN = 16'h0004;
   localparam logic [15:0] XPER_CAN_BOOT = 16'h042d;
   localparam logic [15:0] CAN_SC_BOOT = 16'h0000;
   localparam logic [10:0] ACK_ID = 11'h0e6;
   localparam logic [3:0] ACK_DLC = 4'h3;
   // arbitrary neutral identity values
   localparam logic [7:0] ACK_CODE_DEFAULT = 8'h5a;
   localparam logic [15:0] CHIP_IDENT_DEFAULT = 16'h1230;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int INIT_NS = 1000000;
   localparam int TX_DELAY_NS = 1300000;
   localparam int DLY_W = 16;
   localparam logic [15:0] INIT_CYCLES =
      16'((INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] TX_DELAY_CYCLES =
      16'((TX_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_START, ST_NORMAL, ST_INIT, ST_WAIT_LOW, ST_UART_MEAS,
      ST_CAN_MEAS, ST_CALC, ST_DELAY, ST_LOAD, ST_RUN, ST_FAULT
   } boot_state_t;

   typedef struct packed {
      logic [10:0] id;
      logic [3:0] dlc;
      logic [7:0] data0;
      logic [7:0] data1;
      logic [7:0] data2;
   } ack_msg_t;

   typedef struct packed {
      logic boot_loader_mode;
      logic watchdog_disable;
      logic flash_fetch_block;
      logic can_port_enable;
      logic [15:0] system_config;
      logic [15:0] xbus_peripheral_select;
      logic [15:0] can_status_ctrl;
      logic [15:0] uart_baud_reload;
      logic [5:0] can_brp;
   } boot_cfg_t;

   typedef struct packed {
      boot_state_t state;
      logic uart_s1;
      logic uart_s2;
      logic can_s1;
      logic can_s2;
      logic can_prev;
      logic boot_s1;
      logic boot_s2;
      logic width_s1;
      logic width_s2;
      logic [1:0] strap_cnt;
      logic boot;
      logic src_can;
      logic fault;
      logic [1:0] pre;
      logic [16:0] timer;
      logic [2:0] edges;
      logic [16:0] rem;
      logic [15:0] quo;
      logic [15:0] delay;
      logic [7:0] load_cnt;
      logic [6:0] ram_idx;
      logic uart_tx_oe;
      logic can_tx_oe;
      logic ack_send;
      logic exec_start;
      logic [15:0] rdata;
      boot_cfg_t cfg;
   } boot_ctl_t;

   localparam boot_ctl_t CTL_RESET = '0;

endpackage

// ### serial_boot_autobaud_loader.sv
// boot loader front end: strap capture, baud measurement, tx enable,
// acknowledge object and fixed-length code load into a local ram
// assumes rx lines and straps are asynchronous pins; byte and remote
// request strobes come from same-clock serial controllers
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module serial_boot_autobaud_loader #(
   parameter logic [15:0] INIT_CYCLES = boot_loader_pkg::INIT_CYCLES,
   parameter logic [15:0] TX_DELAY_CYCLES = boot_loader_pkg::TX_DELAY_CYCLES,
   parameter logic [7:0] ACK_CODE = boot_loader_pkg::ACK_CODE_DEFAULT,
   parameter logic [15:0] CHIP_IDENT = boot_loader_pkg::CHIP_IDENT_DEFAULT
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic boot_select_pin,
   input wire logic bus_width_strap,
   input wire logic uart_rx,
   input wire logic can_rx,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic ack_remote_req,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rdata,
   output logic uart_tx_out,
   output logic uart_tx_oe,
   output logic can_tx_pin_out,
   output logic can_tx_pin_oe,
   output boot_loader_pkg::ack_msg_t ack_msg,
   output logic ack_send,
   output logic exec_start,
   output logic [15:0] exec_addr,
   output boot_loader_pkg::boot_cfg_t cfg
);

   boot_loader_pkg::boot_ctl_t st;
   boot_loader_pkg::boot_ctl_t nx;
   // 128 entries cover the longer can load; uart uses the first 32
   logic [7:0] load_ram [0:127];
   logic ram_we;
   logic [16:0] div;

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------

   // one process holds the whole sequence so every flag has one writer
   always_comb begin
      nx = st;
      ram_we = 1'b0;
      div = st.src_can ? boot_loader_pkg::CAN_BRP_DIV : boot_loader_pkg::RELOAD_DIV;
      // pin synchronisers, first stage feeds only the second
      nx.uart_s1 = uart_rx;
      nx.uart_s2 = st.uart_s1;
      nx.can_s1 = can_rx;
      nx.can_s2 = st.can_s1;
      nx.can_prev = st.can_s2;
      nx.boot_s1 = boot_select_pin;
      nx.boot_s2 = st.boot_s1;
      nx.width_s1 = bus_width_strap;
      nx.width_s2 = st.width_s1;
      nx.ack_send = 1'b0;
      nx.exec_start = 1'b0;
      case (st.state)
         // strap sampled once the synchronisers have filled
         boot_loader_pkg::ST_START: begin
            nx.strap_cnt = st.strap_cnt + 2'h1;
            if (st.strap_cnt == 2'h2) begin
               if (!st.boot_s2) begin
                  nx.boot = 1'b1;
                  nx.state = boot_loader_pkg::ST_INIT;
                  nx.cfg.boot_loader_mode = 1'b1;
                  nx.cfg.watchdog_disable = 1'b1;
                  nx.cfg.flash_fetch_block = 1'b1;
                  nx.cfg.system_config = boot_loader_pkg::SYSCFG_BOOT;
                  nx.cfg.system_config[boot_loader_pkg::SYSCFG_BYTE_HIGH_DISABLE_BIT] =
                     st.width_s2;
               end else begin
                  nx.state = boot_loader_pkg::ST_NORMAL;
               end
            end
         end

         // strap high: nothing to do until the next hardware reset
         boot_loader_pkg::ST_NORMAL: begin
            nx.state = boot_loader_pkg::ST_NORMAL;
         end

         // settle time before the lines are watched
         boot_loader_pkg::ST_INIT: begin
            nx.delay = st.delay + 16'h0001;
            if (st.delay == INIT_CYCLES - 16'h0001) begin
               nx.delay = '0;
               nx.state = boot_loader_pkg::ST_WAIT_LOW;
            end
         end

         // can wins a tie since its frame is shorter per bit
         boot_loader_pkg::ST_WAIT_LOW: begin
            nx.timer = '0;
            nx.pre = '0;
            nx.edges = '0;
            if (!st.can_s2) begin
               nx.src_can = 1'b1;
               nx.state = boot_loader_pkg::ST_CAN_MEAS;
               nx.cfg.xbus_peripheral_select = boot_loader_pkg::XPER_CAN_BOOT;
               nx.cfg.can_status_ctrl = boot_loader_pkg::CAN_SC_BOOT;
               nx.cfg.system_config = st.cfg.system_config | boot_loader_pkg::SYSCFG_XPEN;
            end else if (!st.uart_s2) begin
               nx.src_can = 1'b0;
               nx.state = boot_loader_pkg::ST_UART_MEAS;
            end
         end

         // timer ticks at a quarter of the clock, giving nine quarters
         boot_loader_pkg::ST_UART_MEAS: begin
            nx.pre = st.pre + 2'h1;
            if (st.pre == boot_loader_pkg::UART_PRESCALE_LAST) begin
               nx.timer = st.timer + 17'h00001;
            end
            if (st.timer[16]) begin
               nx.fault = 1'b1;
               nx.state = boot_loader_pkg::ST_FAULT;
            end else if (st.uart_s2) begin
               nx.rem = (st.timer >= boot_loader_pkg::RELOAD_OFFSET) ?
                  st.timer - boot_loader_pkg::RELOAD_OFFSET : '0;
               nx.quo = '0;
               nx.state = boot_loader_pkg::ST_CALC;
            end
         end

         // fifth recessive edge closes 29 bit times of the zero frame
         boot_loader_pkg::ST_CAN_MEAS: begin
            nx.timer = st.timer + 17'h00001;
            if (st.timer[16]) begin
               nx.fault = 1'b1;
               nx.state = boot_loader_pkg::ST_FAULT;
            end else if (st.can_s2 && !st.can_prev) begin
               nx.edges = st.edges + 3'h1;
               if (st.edges == boot_loader_pkg::CAN_STUFF_LAST) begin
                  nx.rem = st.timer;
                  nx.quo = '0;
                  nx.state = boot_loader_pkg::ST_CALC;
               end
            end
         end

         // restoring division by repeated subtraction, one step a cycle
         boot_loader_pkg::ST_CALC: begin
            if (st.rem >= div) begin
               nx.rem = st.rem - div;
               nx.quo = st.quo + 16'h0001;
            end else begin
               if (st.src_can) begin
                  nx.cfg.can_brp = st.quo[5:0];
               end else begin
                  nx.cfg.uart_baud_reload = st.quo;
               end
               nx.delay = '0;
               nx.state = boot_loader_pkg::ST_DELAY;
            end
         end

         // the pin stays released so the host sees no early drive
         boot_loader_pkg::ST_DELAY: begin
            nx.delay = st.delay + 16'h0001;
            if (st.delay == TX_DELAY_CYCLES - 16'h0001) begin
               nx.load_cnt = '0;
               nx.state = boot_loader_pkg::ST_LOAD;
               if (st.src_can) begin
                  nx.can_tx_oe = 1'b1;
                  nx.cfg.can_port_enable = 1'b1;
               end else begin
                  nx.uart_tx_oe = 1'b1;
               end
            end
         end

         // bytes land in order from the load base
         boot_loader_pkg::ST_LOAD: begin
            if (rx_byte_valid) begin
               ram_we = 1'b1;
               nx.load_cnt = st.load_cnt + 8'h01;
               if (st.load_cnt == (st.src_can ? boot_loader_pkg::CAN_LOAD_LAST :
                                   boot_loader_pkg::UART_LOAD_LAST)) begin
                  nx.exec_start = 1'b1;
                  nx.state = boot_loader_pkg::ST_RUN;
               end
            end
         end

         // code is loaded; only a restart write or reset leaves
         boot_loader_pkg::ST_RUN: begin
            nx.state = boot_loader_pkg::ST_RUN;
         end

         // parked so a clipped count never reaches the reload
         boot_loader_pkg::ST_FAULT: begin
            nx.state = boot_loader_pkg::ST_FAULT;
         end

         // unused codes fall back to strap sampling
         default: begin
            nx.state = boot_loader_pkg::ST_START;
         end
      endcase

      // object is answered only on a remote request, never on its own
      if (st.src_can && st.cfg.can_port_enable && ack_remote_req) begin
         nx.ack_send = 1'b1;
      end

      // register writes; restart only from idle end states
      if (wr_en) begin
         case (addr)
            boot_loader_pkg::REG_CTRL: begin
               if (wdata[boot_loader_pkg::CTRL_RESTART] && st.boot &&
                   (st.state == boot_loader_pkg::ST_FAULT ||
                    st.state == boot_loader_pkg::ST_RUN)) begin
                  nx.state = boot_loader_pkg::ST_WAIT_LOW;
                  nx.fault = 1'b0;
                  nx.uart_tx_oe = 1'b0;
                  nx.can_tx_oe = 1'b0;
                  nx.cfg.can_port_enable = 1'b0;
               end
            end
            // software may rewrite the can status word after boot
            boot_loader_pkg::REG_CAN_SC: begin
               nx.cfg.can_status_ctrl = wdata;
            end
            boot_loader_pkg::REG_RAM_IDX: begin
               nx.ram_idx = wdata[6:0];
            end
            default: begin
               nx.ram_idx = nx.ram_idx;
            end
         endcase
      end

      // read data valid only in the cycle after the strobe
      nx.rdata = '0;
      if (rd_en) begin
         case (addr)
            boot_loader_pkg::REG_CTRL: nx.rdata = {12'h000, st.state};
            boot_loader_pkg::REG_STATUS: nx.rdata = {10'h000, st.can_tx_oe,
               st.uart_tx_oe, st.state == boot_loader_pkg::ST_RUN, st.src_can,
               st.fault, st.boot};
            boot_loader_pkg::REG_COUNT: nx.rdata = st.timer[15:0];
            boot_loader_pkg::REG_RELOAD: nx.rdata = st.cfg.uart_baud_reload;
            boot_loader_pkg::REG_CAN_BRP: nx.rdata = {10'h000, st.cfg.can_brp};
            boot_loader_pkg::REG_CAN_SC: nx.rdata = st.cfg.can_status_ctrl;
            boot_loader_pkg::REG_SYSCFG: nx.rdata = st.cfg.system_config;
            boot_loader_pkg::REG_XPER: nx.rdata = st.cfg.xbus_peripheral_select;
            boot_loader_pkg::REG_IDENT: nx.rdata = CHIP_IDENT;
            boot_loader_pkg::REG_LOAD_CNT: nx.rdata = {8'h00, st.load_cnt};
            boot_loader_pkg::REG_RAM_IDX: nx.rdata = {9'h000, st.ram_idx};
            boot_loader_pkg::REG_RAM_DATA: nx.rdata = {8'h00, load_ram[st.ram_idx]};
            default: nx.rdata = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------

   // whole control state in one register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= boot_loader_pkg::CTL_RESET;
      end else begin
         st <= nx;
      end
   end

   // load ram has no reset; content is defined only once written
   always_ff @(posedge clk) begin
      if (ram_we) begin
         load_ram[st.load_cnt[6:0]] <= rx_byte;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------

   // pins idle high when driven; oe gates the actual drive
   assign uart_tx_out = 1'b1;
   assign uart_tx_oe = st.uart_tx_oe;
   assign can_tx_pin_out = 1'b1;
   assign can_tx_pin_oe = st.can_tx_oe;

   // acknowledge object is fixed; sending waits for a remote request
   assign ack_msg = '{id: boot_loader_pkg::ACK_ID, dlc: boot_loader_pkg::ACK_DLC,
                      data0: ACK_CODE, data1: CHIP_IDENT[7:0],
                      data2: CHIP_IDENT[15:8]};
   assign ack_send = st.ack_send;
   assign exec_start = st.exec_start;
   // jump target is always the first loaded byte
   assign exec_addr = boot_loader_pkg::LOAD_BASE;
   assign cfg = st.cfg;
   assign rdata = st.rdata;

endmodule

// ### serial_boot_autobaud_loader_checker.sv
// concurrent checks on the boot loader front end ports
// assumes one clock, async high reset, package compiled first
`timescale 1ns/100ps
module serial_boot_autobaud_loader_checker #(
   parameter logic [7:0] ACK_CODE = 8'h00,
   parameter logic [15:0] CHIP_IDENT = 16'h0000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ack_remote_req,
   input wire logic uart_tx_out,
   input wire logic uart_tx_oe,
   input wire logic can_tx_pin_out,
   input wire logic can_tx_pin_oe,
   input wire boot_loader_pkg::ack_msg_t ack_msg,
   input wire logic ack_send,
   input wire logic exec_start,
   input wire boot_loader_pkg::boot_cfg_t cfg
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_ack_on_req: assert property (ack_remote_req && cfg.can_port_enable |=> ack_send)
      else $error("ack missing after remote request");
   a_ack_only_req: assert property (ack_send |-> $past(ack_remote_req))
      else $error("ack sent without remote request");
   a_ack_fields: assert property (ack_msg ==
      {11'h0e6, 4'h3, ACK_CODE, CHIP_IDENT[7:0], CHIP_IDENT[15:8]})
      else $error("ack object contents wrong");
   a_boot_guards: assert property (cfg.boot_loader_mode |->
      cfg.watchdog_disable && cfg.flash_fetch_block)
      else $error("watchdog or flash guard off in boot mode");
   a_rom_enable: assert property (cfg.boot_loader_mode |-> cfg.system_config[10])
      else $error("internal memory enable clear in boot mode");
   a_tx_pins_high: assert property (uart_tx_out && can_tx_pin_out)
      else $error("tx pin not driven high");
   a_can_oe_cfg: assert property (can_tx_pin_oe |-> cfg.can_port_enable &&
      cfg.xbus_peripheral_select == 16'h042d)
      else $error("can tx driven with port unconfigured");
   a_exec_pulse: assert property (exec_start |=> !exec_start)
      else $error("exec start longer than one cycle");
   a_exec_ready: assert property (exec_start |-> uart_tx_oe || can_tx_pin_oe)
      else $error("exec start before tx enabled");
   a_mode_holds: assert property (cfg.boot_loader_mode |=> cfg.boot_loader_mode)
      else $error("boot mode left without reset");
endmodule

bind serial_boot_autobaud_loader serial_boot_autobaud_loader_checker #(
   .ACK_CODE(ACK_CODE), .CHIP_IDENT(CHIP_IDENT)) i_chk (.clk, .sys_rst, .ack_remote_req,
   .uart_tx_out, .uart_tx_oe, .can_tx_pin_out, .can_tx_pin_oe, .ack_msg, .ack_send,
   .exec_start, .cfg);

// ### boot_host_model.sv
// programming host on the far side: zero byte, zero frame, code bytes
// assumes callers enter each task right after a rising clock edge
`timescale 1ns/100ps
module boot_host_model (
   input wire logic clk,
   output logic uart_rx,
   output logic can_rx,
   output logic rx_byte_valid,
   output logic [7:0] rx_byte,
   output logic ack_remote_req
);
   // ---------------------------------------------------------------
   // line levels and transfers
   // ---------------------------------------------------------------
   // lines idle high, as with the external pull-ups
   initial begin
      uart_rx = 1'b1;
      can_rx = 1'b1;
      rx_byte_valid = 1'b0;
      rx_byte = 8'h00;
      ack_remote_req = 1'b0;
   end
   // hold one line at a level for n clocks
   task automatic line(input bit can, input logic lvl, input int n);
      if (can) can_rx <= lvl;
      else uart_rx <= lvl;
      repeat (n) @(posedge clk);
   endtask
   // start plus eight zeros; line left high as stop bit and idle
   task automatic zero_byte(input int bt);
      line(0, 1'b0, 9 * bt);
      uart_rx <= 1'b1;
   endtask
   // zero id, zero length frame up to its fifth stuff bit
   task automatic frame_head(input int bt);
      for (int i = 0; i < 5; i++) begin
         line(1, 1'b0, 5 * bt);
         if (i < 4) line(1, 1'b1, bt);
      end
   endtask
   // rest of the frame; the missing ack slot is why a real host resends
   task automatic frame_tail(input int bt);
      line(1, 1'b1, bt);
      line(1, 1'b0, 4 * bt);
      line(1, 1'b1, bt);
      line(1, 1'b0, bt);
      line(1, 1'b1, 11 * bt);
   endtask
   // back-to-back code bytes; data toggles once released
   task automatic send_bytes(input int n);
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         rx_byte_valid <= 1'b1;
         rx_byte <= 8'(i * 7 + 3);
         @(posedge clk);
      end
      rx_byte_valid <= 1'b0;
      rx_byte <= ~rx_byte;
   endtask
   task automatic remote;
      ack_remote_req <= 1'b1;
      @(posedge clk);
      ack_remote_req <= 1'b0;
   endtask
endmodule

// ### test_serial_boot_autobaud_loader.sv
// self-checking bench: uart boot, can boot, normal start, can overflow
// assumes the host model and bound checker are compiled alongside
`timescale 1ns/100ps
module test_serial_boot_autobaud_loader;
   // arbitrary neutral identity values
   localparam logic [7:0] ACK_CODE = 8'h3e;
   localparam logic [15:0] CHIP_IDENT = 16'h4c21;
   logic clk = 0, sys_rst, boot_select_pin, bus_width_strap;
   logic wr_en, rd_en, rx_byte_valid, ack_remote_req, uart_rx, can_rx;
   logic uart_tx_out, uart_tx_oe, can_tx_pin_out, can_tx_pin_oe, ack_send, exec_start;
   logic [7:0] addr, rx_byte;
   logic [15:0] wdata, rdata, exec_addr;
   boot_loader_pkg::ack_msg_t ack_msg;
   boot_loader_pkg::boot_cfg_t cfg;
   int n_mismatch = 0, checked = 0;

   always #20 clk = ~clk;

   serial_boot_autobaud_loader #(.INIT_CYCLES(16'h0004), .TX_DELAY_CYCLES(16'h0008),
      .ACK_CODE(ACK_CODE), .CHIP_IDENT(CHIP_IDENT)) i_dut (.clk, .sys_rst,
      .boot_select_pin, .bus_width_strap, .uart_rx, .can_rx, .rx_byte_valid, .rx_byte,
      .ack_remote_req, .addr, .wdata, .wr_en, .rd_en, .rdata, .uart_tx_out, .uart_tx_oe,
      .can_tx_pin_out, .can_tx_pin_oe, .ack_msg, .ack_send, .exec_start, .exec_addr, .cfg);
   boot_host_model i_host (.clk, .uart_rx, .can_rx, .rx_byte_valid, .rx_byte,
      .ack_remote_req);

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // straps held across release so the sampled level is stable
   task automatic reset(input logic sel, input logic w);
      sys_rst <= 1'b1;
      boot_select_pin <= sel;
      bus_width_strap <= w;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      chk(nm, rdata, exp);
      // hand back right after a rising edge, as every caller expects
      @(posedge clk);
   endtask
   function automatic logic sig(input int s);
      return s == 0 ? uart_tx_oe : s == 1 ? can_tx_pin_oe : exec_start;
   endfunction
   // bounded wait, n counts edges passed
   task automatic wait_for(input int s, output int n);
      n = 0;
      #1;
      while (sig(s) !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 400) begin
            n_mismatch++;
            test_done();
         end
      end
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      int n;
      // bus idle before the first edge; the reset task drives the straps
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      addr <= 8'h00;
      wdata <= 16'h0000;
      // uart boot, wide bus strap; 192 clocks a bit matches reload 5 exactly
      reset(1'b0, 1'b1);
      chk("guards", 16'({cfg.watchdog_disable, cfg.flash_fetch_block}), 16'h0003);
      rchk("syscfg", boot_loader_pkg::REG_SYSCFG, 16'h0600);
      i_host.zero_byte(192);
      wait_for(0, n);
      chk("uart oe delay", 16'(n > 8), 16'h0001);
      rchk("reload", boot_loader_pkg::REG_RELOAD, 16'h0005);
      chk("baud div", 16'(32 * (cfg.uart_baud_reload + 1)), 16'h00c0);
      i_host.remote();
      @(negedge clk);
      chk("uart ack", 16'(ack_send), 16'h0000);
      i_host.send_bytes(32);
      wait_for(2, n);
      chk("uart exec", 16'(n), 16'h0000);
      chk("exec addr", exec_addr, 16'hfa40);
      wr(boot_loader_pkg::REG_RAM_IDX, 16'h001f);
      rchk("uart ram", boot_loader_pkg::REG_RAM_DATA, 16'h00dc);
      rchk("unmapped", 8'hfe, 16'h0000);
      // can boot, narrow bus strap; 75 clocks a bit gives 2175 ticks
      reset(1'b0, 1'b0);
      i_host.frame_head(75);
      fork
         i_host.frame_tail(75);
         wait_for(1, n);
      join
      chk("can oe delay", 16'(n > 8), 16'h0001);
      chk("can enable", 16'(cfg.can_port_enable), 16'h0001);
      chk("brp", 16'(cfg.can_brp), 16'h0001);
      chk("xbus", cfg.xbus_peripheral_select, 16'h042d);
      chk("can sc", cfg.can_status_ctrl, 16'h0000);
      chk("can syscfg", cfg.system_config, 16'h0404);
      i_host.remote();
      @(negedge clk);
      chk("can ack", 16'(ack_send), 16'h0001);
      chk("ack head", 16'({ack_msg.id, ack_msg.dlc}), 16'h0e63);
      chk("ack data", {ack_msg.data2, ack_msg.data1}, CHIP_IDENT);
      chk("ack code", 16'(ack_msg.data0), 16'(ACK_CODE));
      @(negedge clk);
      chk("ack pulse", 16'(ack_send), 16'h0000);
      i_host.send_bytes(128);
      wait_for(2, n);
      chk("can exec", 16'(n), 16'h0000);
      rchk("can count", boot_loader_pkg::REG_LOAD_CNT, 16'h0080);
      wr(boot_loader_pkg::REG_RAM_IDX, 16'h007f);
      rchk("can ram", boot_loader_pkg::REG_RAM_DATA, 16'h007c);
      // strap high: normal start
      reset(1'b1, 1'b0);
      chk("normal", 16'(cfg.boot_loader_mode), 16'h0000);
      wr(boot_loader_pkg::REG_CTRL, 16'h0001);
      rchk("no restart", boot_loader_pkg::REG_CTRL, 16'(boot_loader_pkg::ST_NORMAL));
      // can line held low past the 16-bit range
      reset(1'b0, 1'b0);
      i_host.line(1, 1'b0, 66000);
      i_host.line(1, 1'b1, 4);
      rchk("fault", boot_loader_pkg::REG_STATUS, 16'h0007);
      rchk("no brp", boot_loader_pkg::REG_CAN_BRP, 16'h0000);
      // restart leaves the fault and watches the lines again
      wr(boot_loader_pkg::REG_CTRL, 16'h0001);
      rchk("restart", boot_loader_pkg::REG_STATUS, 16'h0005);
      rchk("rewait", boot_loader_pkg::REG_CTRL, 16'(boot_loader_pkg::ST_WAIT_LOW));
      wr(boot_loader_pkg::REG_CAN_SC, 16'h00a5);
      rchk("sc write", boot_loader_pkg::REG_CAN_SC, 16'h00a5);
      test_done();
   end
endmodule
